// File: rtl/pipwm_chan.sv
`timescale 1ns/10ps
module pipwm_chan
   import pipwm_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic rstn, // Sync reset, active low
   pipwm_chan_if.chan tb, // Shared phase
   input wire logic [3:0] code, // Stored code
   output logic sink_on // Sink current when high
);
   logic [3:0] active_q;
   logic sink_d;

   // Load new code at period boundary, or at any cycle while PWM is stopped
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         active_q <= PIPWM_PHASE_RESET;
      else if (tb.period_end || !tb.pwm_run)
         active_q <= code; // [R7]
   end

   always_comb
   begin
      if (active_q == PIPWM_CODE_STATIC || !tb.pwm_run)
         sink_d = 1'b1; // [R5] [R6]
      else
         sink_d = (tb.phase <= active_q); // [R4]
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         sink_on <= 1'b0;
      else
         sink_on <= sink_d;
   end
endmodule : pipwm_chan

// File: rtl/pipwm_chan_if.sv
`timescale 1ns/10ps
interface pipwm_chan_if;
   import pipwm_pkg::*;
   logic [3:0] phase;
   logic period_end;
   logic pwm_run;
   modport ctrl (output phase, output period_end, output pwm_run);
   modport chan (input phase, input period_end, input pwm_run);
endinterface : pipwm_chan_if

// File: rtl/pipwm_pkg.sv
package pipwm_pkg;
   localparam int unsigned PIPWM_PORTS = 8;
   localparam int unsigned PIPWM_REGS = 4;
   localparam logic [7:0] PIPWM_ADDR_P10 = 8'h10;
   localparam logic [7:0] PIPWM_ADDR_P32 = 8'h11;
   localparam logic [7:0] PIPWM_ADDR_P54 = 8'h12;
   localparam logic [7:0] PIPWM_ADDR_P76 = 8'h13;
   localparam logic [7:0] PIPWM_REG_RESET = 8'h00;
   localparam int unsigned PIPWM_HI_NIB_LSB = 4;
   localparam int unsigned PIPWM_LO_NIB_LSB = 0;
   localparam logic [3:0] PIPWM_CODE_STATIC = 4'hF;
   localparam logic [3:0] PIPWM_MASTER_OFF = 4'h0;
   localparam logic [3:0] PIPWM_PHASE_LAST = 4'hF;
   localparam logic [3:0] PIPWM_PHASE_RESET = 4'h0;
   localparam logic [7:0] PIPWM_RDATA_RESET = 8'h00;
   localparam logic [7:0] PIPWM_DRV_RESET = 8'h00;
endpackage : pipwm_pkg

// File: rtl/pipwm_top.sv
// Function
// [R1] 0x10 holds port one high, zero low
// [R2] 0x11-0x13 hold odd high, even low pairs
// [R3] Write stores both nibbles, read returns them
// [R4] Codes 0-14 give code+1 sixteenths duty
// [R5] Code 15 gives static full level
// [R6] Master zero stops PWM, outputs static
// [R7] New code applies at next period start
`timescale 1ns/10ps
module pipwm_top
   import pipwm_pkg::*;
(
   input wire logic mclk, // 125 MHz clock
   input wire logic rstn, // Sync reset, active low
   input wire logic acc_valid, // Host access strobe, one cycle
   input wire logic acc_rnw, // 1 read, 0 write
   input wire logic [7:0] acc_addr, // Register address
   input wire logic [7:0] acc_wdata, // Write data
   input wire logic [3:0] master_level, // Master intensity field
   output logic [7:0] acc_rdata, // Read data
   output logic acc_hit, // Access hit a register, one cycle
   output logic [7:0] port_drv_oe, // Drive low when high
   output logic [7:0] port_drv_o // Always low
);
   logic [7:0] reg_p10_q; // Ports one and zero
   logic [7:0] reg_p10_d;
   logic [7:0] reg_p32_q; // Ports three and two
   logic [7:0] reg_p32_d;
   logic [7:0] reg_p54_q; // Ports five and four
   logic [7:0] reg_p54_d;
   logic [7:0] reg_p76_q; // Ports seven and six
   logic [7:0] reg_p76_d;
   logic [7:0] rdata_d;
   logic hit_d;
   logic [3:0] phase_q;
   logic [3:0] phase_d;
   logic run_q;
   logic run_d;
   logic [3:0] sel;
   logic in_map;
   logic wr_en;
   logic rd_en;
   logic [7:0] rd_word;
   logic [3:0] code [PIPWM_PORTS];
   logic [7:0] sink;
   pipwm_chan_if tb ();

   always_comb
   begin
      sel = 4'h0;
      case (acc_addr)
         PIPWM_ADDR_P10: sel = 4'h1; // [R1]
         PIPWM_ADDR_P32: sel = 4'h2; // [R2]
         PIPWM_ADDR_P54: sel = 4'h4; // [R2]
         PIPWM_ADDR_P76: sel = 4'h8; // [R2]
         default: sel = 4'h0;
      endcase
   end

   assign in_map = (sel != 4'h0);
   assign wr_en = acc_valid && !acc_rnw && in_map; // [R3]
   assign rd_en = acc_valid && acc_rnw;

   // Only a mapped address may change a register
   always_comb
   begin
      reg_p10_d = reg_p10_q;
      reg_p32_d = reg_p32_q;
      reg_p54_d = reg_p54_q;
      reg_p76_d = reg_p76_q;
      if (wr_en)
      begin
         case (sel)
            4'h1: reg_p10_d = acc_wdata; // [R1] [R3]
            4'h2: reg_p32_d = acc_wdata; // [R2] [R3]
            4'h4: reg_p54_d = acc_wdata; // [R2] [R3]
            4'h8: reg_p76_d = acc_wdata; // [R2] [R3]
            default: reg_p10_d = reg_p10_q;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         reg_p10_q <= PIPWM_REG_RESET;
      else
         reg_p10_q <= reg_p10_d;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         reg_p32_q <= PIPWM_REG_RESET;
      else
         reg_p32_q <= reg_p32_d;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         reg_p54_q <= PIPWM_REG_RESET;
      else
         reg_p54_q <= reg_p54_d;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         reg_p76_q <= PIPWM_REG_RESET;
      else
         reg_p76_q <= reg_p76_d;
   end

   always_comb
   begin
      rd_word = PIPWM_RDATA_RESET;
      case (sel)
         4'h1: rd_word = reg_p10_q; // [R1]
         4'h2: rd_word = reg_p32_q; // [R2]
         4'h4: rd_word = reg_p54_q; // [R2]
         4'h8: rd_word = reg_p76_q; // [R2]
         default: rd_word = PIPWM_RDATA_RESET;
      endcase
   end

   always_comb
   begin
      hit_d = acc_valid && in_map;
      rdata_d = acc_rdata;
      if (rd_en)
         rdata_d = rd_word; // [R3]
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         acc_hit <= 1'b0;
      else
         acc_hit <= hit_d;
   end

   // Read data holds until the next read
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         acc_rdata <= PIPWM_RDATA_RESET;
      else
         acc_rdata <= rdata_d;
   end

   // Upper nibble is the odd port, lower nibble the even port
   always_comb
   begin
      code[0] = reg_p10_q[PIPWM_LO_NIB_LSB +: 4]; // [R1]
      code[1] = reg_p10_q[PIPWM_HI_NIB_LSB +: 4]; // [R1]
      code[2] = reg_p32_q[PIPWM_LO_NIB_LSB +: 4]; // [R2]
      code[3] = reg_p32_q[PIPWM_HI_NIB_LSB +: 4]; // [R2]
      code[4] = reg_p54_q[PIPWM_LO_NIB_LSB +: 4]; // [R2]
      code[5] = reg_p54_q[PIPWM_HI_NIB_LSB +: 4]; // [R2]
      code[6] = reg_p76_q[PIPWM_LO_NIB_LSB +: 4]; // [R2]
      code[7] = reg_p76_q[PIPWM_HI_NIB_LSB +: 4]; // [R2]
   end

   // Oscillator stopped while master level is zero
   always_comb
   begin
      run_d = (master_level != PIPWM_MASTER_OFF); // [R6]
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         run_q <= 1'b0;
      else
         run_q <= run_d;
   end

   always_comb
   begin
      if (!run_q)
         phase_d = PIPWM_PHASE_RESET; // [R6]
      else
         phase_d = phase_q + 4'h1;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         phase_q <= PIPWM_PHASE_RESET;
      else
         phase_q <= phase_d;
   end

   assign tb.phase = phase_q;
   assign tb.period_end = (phase_q == PIPWM_PHASE_LAST); // [R7]
   assign tb.pwm_run = run_q;

   for (genvar p = 0; p < PIPWM_PORTS; p++)
   begin : g_chan
      pipwm_chan u_chan (
         .mclk(mclk),
         .rstn(rstn),
         .tb(tb),
         .code(code[p]), // [R1] [R2]
         .sink_on(sink[p])
      );
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         port_drv_oe <= PIPWM_DRV_RESET;
      else
         port_drv_oe <= sink;
   end

   // Open drain: the data side only ever pulls low
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         port_drv_o <= PIPWM_DRV_RESET;
      else
         port_drv_o <= PIPWM_DRV_RESET;
   end
endmodule : pipwm_top

// File: testbench/pipwm_load.sv
`timescale 1ns/10ps
module pipwm_load (
   input wire logic [7:0] port_drv_oe, // Sink enables
   input wire logic [7:0] port_drv_o, // Driven level
   output logic [7:0] pin // Port levels
);
   // Driven level while enabled, pull-up when released
   assign pin = (port_drv_oe & port_drv_o) | ~port_drv_oe;
endmodule : pipwm_load

// File: testbench/pipwm_properties.sv
`timescale 1ns/10ps
module pipwm_chk (
   input wire logic mclk, // Clock
   input wire logic rstn, // Reset
   input wire logic acc_valid, // Strobe
   input wire logic acc_rnw, // Read flag
   input wire logic [7:0] acc_addr, // Address
   input wire logic [3:0] master_level, // Master
   input wire logic [7:0] acc_rdata, // Read data
   input wire logic acc_hit, // Hit
   input wire logic [7:0] port_drv_oe, // Sinks
   input wire logic [7:0] port_drv_o // Data
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   chk_hit_map: assert property (
      acc_valid |=> acc_hit == ($past(acc_addr[7:2]) == 6'h04)) else $error("hit");
   chk_hit_idle: assert property (
      !acc_valid |=> !acc_hit) else $error("idle hit");
   chk_master_off: assert property (
      (master_level == 4'h0) [*6] |-> port_drv_oe == 8'hFF) else $error("m0");
   chk_drv_low: assert property (
      port_drv_o == 8'h00) else $error("drv");
   chk_rdata_hold: assert property (
      !(acc_valid && acc_rnw) |=> $stable(acc_rdata)) else $error("rdata");
   chk_miss_zero: assert property (
      acc_valid && acc_rnw && acc_addr[7:2] != 6'h04 |=> acc_rdata == 8'h00)
      else $error("miss");
   cover property (acc_hit);
   cover property (master_level == 4'h0 ##1 master_level != 4'h0);
   cover property ($fell(port_drv_oe[0]));
endmodule : pipwm_chk
bind pipwm_top pipwm_chk u_chk (.mclk, .rstn, .acc_valid, .acc_rnw,
   .acc_addr, .master_level, .acc_rdata, .acc_hit, .port_drv_oe,
   .port_drv_o);

// File: testbench/pipwm_top_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
   miscompares++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module pipwm_top_tb_top;
   import pipwm_pkg::*;
   logic mclk = 0, rstn = 0, acc_valid = 0, acc_rnw = 0, acc_hit;
   logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00;
   logic [7:0] acc_rdata, port_drv_oe, port_drv_o, pin;
   logic [3:0] master_level = 4'h8;
   int miscompares = 0, comparisons = 0, cyc = 0, lows;
   logic [23:0] rows [5] = '{24'h10E0E0, 24'h113C3C, 24'h125A5A,
      24'h13F1F1, 24'h147700};
   pipwm_top dut (.mclk, .rstn, .acc_valid, .acc_rnw, .acc_addr,
      .acc_wdata, .master_level, .acc_rdata, .acc_hit, .port_drv_oe,
      .port_drv_o);
   pipwm_load load (.port_drv_oe, .port_drv_o, .pin);
   always #4 mclk = ~mclk;
   task automatic acc(input logic rnw, input logic [7:0] a, d);
      @(negedge mclk);
      acc_valid = 1;
      acc_rnw = rnw;
      acc_addr = a;
      acc_wdata = d;
      @(negedge mclk);
      acc_valid = 0;
   endtask : acc
   task automatic duty(input int p, input int e);
      lows = 0;
      repeat (16) @(negedge mclk) lows += (pin[p] === 1'b0);
      `CHK("duty", e, lows)
   endtask : duty
   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         miscompares++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (10) @(negedge mclk);
      rstn = 1;
      `CHK("rst", 8'h00, acc_rdata)
      foreach (rows[i])
      begin
         acc(0, rows[i][23:16], rows[i][15:8]);
         acc(1, rows[i][23:16], 8'h00);
         `CHK("rdata", rows[i][7:0], acc_rdata)
         `CHK("hit", rows[i][23:16] < 8'h14, acc_hit)
      end
      repeat (40) @(negedge mclk);
      duty(0, 1);
      duty(1, 15);
      duty(6, 2);
      duty(7, 16);
      master_level = 4'h0;
      repeat (8) @(negedge mclk);
      duty(0, 16);
      master_level = 4'h8;
      acc(1, 8'h10, 8'h00);
      `CHK("alias", 8'hE0, acc_rdata)
      repeat (4) @(negedge mclk);
      do @(negedge mclk); while (pin[0] !== 1'b0);
      acc(0, 8'h10, 8'hE7);
      lows = 0;
      repeat (13) @(negedge mclk) lows += (pin[0] === 1'b0);
      `CHK("old period", 0, lows)
      duty(0, 8);
      @(negedge mclk);
      rstn = 0;
      repeat (3) @(negedge mclk);
      `CHK("rst hit", 1'b0, acc_hit)
      `CHK("rst rdata", 8'h00, acc_rdata)
      rstn = 1;
      acc(1, 8'h13, 8'h00);
      `CHK("rst reg", 8'h00, acc_rdata)
      repeat (20) @(negedge mclk);
      duty(0, 1);
      give_verdict();
   end
endmodule : pipwm_top_tb_top
